/* File: rtl/sfq_map.svh */
// Opcodes, status layout and timing constants of the flash command block
`ifndef SFQ_MAP_SVH
`define SFQ_MAP_SVH

// Command opcodes
`define SFQ_OP_SET_WL 8'h06
`define SFQ_OP_CLR_WL 8'h04
`define SFQ_OP_VOL_WE 8'h50
`define SFQ_OP_STAT_RD_LO 8'h05
`define SFQ_OP_STAT_RD_HI 8'h35
`define SFQ_OP_STAT_WR 8'h01
`define SFQ_OP_READ 8'h03
`define SFQ_OP_FAST 8'h0B
`define SFQ_OP_DUAL_OUT 8'h3B
`define SFQ_OP_QUAD_OUT 8'h6B
`define SFQ_OP_DUAL_IO 8'hBB
`define SFQ_OP_MODE_RST 8'hFF

// Continuous mode key in the upper mode nibble
`define SFQ_CONT_KEY 4'hA

// Status register layout
`define SFQ_SR_RESET 16'h0000
`define SFQ_SR_MASK 16'h47FC
`define SFQ_SR_LOW 16'h00FF
`define SFQ_SR_CLR_ONE 16'hBDFF
`define SFQ_BIT_SRP 7

// Per-phase sample counts (last index; status write byte counts are totals)
`define SFQ_CNT_OPC 6'h07
`define SFQ_CNT_ADDR1 6'h17
`define SFQ_CNT_ADDR2 6'h0F
`define SFQ_CNT_DUMMY 6'h07
`define SFQ_CNT_BYTE1 6'h08
`define SFQ_CNT_BYTE2 6'h10
`define SFQ_CNT_MAX 6'h3F

// Line output enables per width
`define SFQ_OE_W1 4'h2
`define SFQ_OE_W2 4'h3
`define SFQ_OE_W4 4'hF

// Pin synchroniser reset: chip select and write protect idle high
`define SFQ_PIN_RESET 7'h60
`define SFQ_UNDERRUN 8'hFF

// Timing and buffering
`define SFQ_CLK_NS 10
`define SFQ_TW_US 5
`define SFQ_BYTE_W 8
`define SFQ_FIFO_DEPTH 4

`endif

/* File: rtl/sfq_pkg.sv */
// Types shared by the flash command block
package sfq_pkg;

    // Frame phases, gray coded along opcode-address-dummy-data
    typedef enum logic [2:0] {
        SFQ_IDLE = 3'h0,
        SFQ_OPC = 3'h1,
        SFQ_ADDR = 3'h3,
        SFQ_DUMMY = 3'h2,
        SFQ_DATA = 3'h6,
        SFQ_STAT_IN = 3'h7,
        SFQ_IGNORE = 3'h5
    } sfq_state_t;

    // Lines used per serial clock
    typedef enum logic [1:0] {
        SFQ_W1 = 2'h0,
        SFQ_W2 = 2'h1,
        SFQ_W4 = 2'h2
    } sfq_wid_t;

    // Source of outgoing bytes
    typedef enum logic [1:0] {
        SFQ_SRC_LO = 2'h0,
        SFQ_SRC_HI = 2'h1,
        SFQ_SRC_ARRAY = 2'h2
    } sfq_src_t;

    // Drive of the four data lines
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] val;
    } sfq_drive_t;

endpackage

/* File: rtl/sfq_flash.sv */
// Serial flash command front end with read data buffer
`timescale 1ns/1ps
`include "sfq_map.svh"

// Small synchronous FIFO between array and link shifter
module sfq_fifo #(
    parameter int WIDTH = `SFQ_BYTE_W,
    parameter int DEPTH = `SFQ_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Honest full and empty
    assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];

    // Storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clock_i) begin
        if (!rstn_i || flush_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= AW'(wr_q + (push ? 1 : 0));
            rd_q <= AW'(rd_q + (pop ? 1 : 0));
            cnt_q <= (AW+1)'(cnt_q + (push ? 1 : 0) - (pop ? 1 : 0));
        end
    end
endmodule

// Contract
// - Opcode 06h sets write enable latch
// - Opcode 04h clears write enable latch
// - Latch clears at reset and operation end
// - 05h/35h stream status low/high byte repeatedly
// - Status reads accepted even while busy
// - Status write needs latch set first (code also accepts it straight after volatile enable 50h, latch clear)
// - Bits 15,13,12,11,1,0 never written
// - Status write ends after 8/16 bits only
// - One-byte write clears complement and quad
// - Timed cycle holds progress flag, clears latch
// - Protect bits follow pin; hardware protect blocks
// - Volatile enable must directly precede status write
// - Volatile enable never sets write latch
// - Plain read: 24-bit address, auto increment
// - Reads rejected while internal cycle runs
// - Fast read adds one dummy byte
// - Dual output: line 1 odd, line 0 even
// - Quad output: lines 3..0 carry nibbles
// - Dual I/O address and mode two bits/clock
// - Mode Ax skips opcode on next frame
module sfq_flash #(
    parameter int unsigned TW_CYCLES = `SFQ_TW_US * 1000 / `SFQ_CLK_NS
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Link pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic wp_n_i,
    input wire logic [3:0] line_i,
    output logic [3:0] line_o,
    output logic [3:0] line_oe_o,
    // Array side
    input wire logic busy_i,
    input wire logic op_done_i,
    output logic [23:0] mem_addr_o,
    output logic mem_fetch_o,
    input wire logic mem_valid_i,
    input wire logic [7:0] mem_data_i,
    output logic mem_ready_o,
    // Status view
    output logic [15:0] status_o,
    output logic write_enable_latch_o,
    output logic write_in_progress_o,
    output logic cont_mode_o
);
    import sfq_pkg::*;

    // Bits shifted per clock for a width
    function automatic logic [2:0] sfq_step(input sfq_wid_t w);
        unique case (w)
            SFQ_W2: return 3'h2;
            SFQ_W4: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction

    // Top bits of a byte onto the lines
    function automatic sfq_drive_t sfq_map(input logic [7:0] b,
                                           input sfq_wid_t w);
        sfq_drive_t d;
        d = '0;
        unique case (w)
            SFQ_W1: begin
                d.oe = `SFQ_OE_W1;
                d.val = {2'b00, b[7], 1'b0};
            end
            SFQ_W2: begin
                d.oe = `SFQ_OE_W2;
                d.val = {2'b00, b[7:6]};
            end
            default: begin
                d.oe = `SFQ_OE_W4;
                d.val = b[7:4];
            end
        endcase
        return d;
    endfunction

    logic [6:0] meta_q, sync_q, prev_q;
    sfq_state_t state_q, state_d;
    sfq_wid_t owid_q, owid_d;
    sfq_src_t src_q, src_d;
    sfq_drive_t drive_q, drive_d;
    logic dual_q, dual_d, dum_q, dum_d;
    logic [5:0] cnt_q, cnt_d;
    logic [31:0] in_q;
    logic [7:0] sh_q;
    logic [2:0] ocnt_q;
    logic [15:0] sr_q;
    logic wel_q, vwe_q, vuse_q, wip_q, cont_q, fetch_q;
    logic [31:0] tcnt_q;
    logic [23:0] addr_q;
    logic ff_in_ready, ff_valid;
    logic [7:0] ff_data;

    // Two-stage synchroniser, third stage for edges
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            meta_q <= `SFQ_PIN_RESET;
            sync_q <= `SFQ_PIN_RESET;
            prev_q <= `SFQ_PIN_RESET;
        end else begin
            meta_q <= {wp_n_i, cs_n_i, sclk_i, line_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Pin events
    wire [3:0] lin = sync_q[3:0];
    wire cs_act = !sync_q[5];
    wire cs_fall = !sync_q[5] && prev_q[5];
    wire cs_rise = sync_q[5] && !prev_q[5];
    wire wp_low = !sync_q[6];
    wire rise = sync_q[4] && !prev_q[4] && cs_act;
    wire fall = !sync_q[4] && prev_q[4] && cs_act;

    // Incoming bits, one or two lines
    wire [31:0] in_next = dual_q ? {in_q[29:0], lin[1], lin[0]}
                                 : {in_q[30:0], lin[0]};
    wire [7:0] opc = in_next[7:0];
    wire opc_done = rise && state_q == SFQ_OPC
                    && cnt_q == `SFQ_CNT_OPC;
    wire [5:0] addr_last = dual_q ? `SFQ_CNT_ADDR2 : `SFQ_CNT_ADDR1;
    wire addr_done = rise && state_q == SFQ_ADDR
                     && cnt_q == addr_last;
    wire dummy_done = rise && state_q == SFQ_DUMMY
                      && cnt_q == `SFQ_CNT_DUMMY;

    // Guards for busy and protection
    wire busy_all = busy_i || wip_q;
    wire hw_prot = sr_q[`SFQ_BIT_SRP] && wp_low;
    wire wr_ok = (wel_q || vwe_q) && !hw_prot;
    wire [15:0] sr_view = {sr_q[15:2], wel_q, busy_all};

    // Frame sequencing
    always_comb begin
        state_d = state_q;
        dual_d = dual_q;
        owid_d = owid_q;
        dum_d = dum_q;
        src_d = src_q;
        cnt_d = cnt_q;
        if (rise && cnt_q != `SFQ_CNT_MAX) begin
            cnt_d = cnt_q + 6'h01;
        end
        if (cs_rise || !cs_act) begin
            state_d = SFQ_IDLE;
        end else if (cs_fall) begin
            cnt_d = '0;
            dual_d = cont_q;
            owid_d = SFQ_W2;
            dum_d = 1'b0;
            src_d = SFQ_SRC_ARRAY;
            if (!cont_q) begin
                state_d = SFQ_OPC;
            end else begin
                state_d = busy_all ? SFQ_IGNORE : SFQ_ADDR;
            end
        end else if (opc_done) begin
            cnt_d = '0;
            dual_d = 1'b0;
            dum_d = 1'b0;
            owid_d = SFQ_W1;
            state_d = SFQ_IGNORE;
            case (opc)
                `SFQ_OP_STAT_RD_LO, `SFQ_OP_STAT_RD_HI: begin
                    state_d = SFQ_DATA;
                    src_d = (opc == `SFQ_OP_STAT_RD_HI) ? SFQ_SRC_HI
                                                        : SFQ_SRC_LO;
                end
                `SFQ_OP_STAT_WR: begin
                    state_d = wr_ok ? SFQ_STAT_IN : SFQ_IGNORE;
                end
                `SFQ_OP_READ, `SFQ_OP_FAST, `SFQ_OP_DUAL_OUT,
                `SFQ_OP_QUAD_OUT, `SFQ_OP_DUAL_IO: begin
                    state_d = busy_all ? SFQ_IGNORE : SFQ_ADDR;
                    src_d = SFQ_SRC_ARRAY;
                    dual_d = opc == `SFQ_OP_DUAL_IO;
                    dum_d = opc != `SFQ_OP_READ
                            && opc != `SFQ_OP_DUAL_IO;
                    if (opc == `SFQ_OP_QUAD_OUT) begin
                        owid_d = SFQ_W4;
                    end else if (opc == `SFQ_OP_DUAL_OUT
                                 || opc == `SFQ_OP_DUAL_IO) begin
                        owid_d = SFQ_W2;
                    end
                end
                default: state_d = SFQ_IGNORE;
            endcase
        end else if (addr_done) begin
            cnt_d = '0;
            state_d = dum_q ? SFQ_DUMMY : SFQ_DATA;
        end else if (dummy_done) begin
            cnt_d = '0;
            state_d = SFQ_DATA;
        end
    end

    // Phase registers
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state_q <= SFQ_IDLE;
            dual_q <= 1'b0;
            owid_q <= SFQ_W1;
            dum_q <= 1'b0;
            src_q <= SFQ_SRC_LO;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            dual_q <= dual_d;
            owid_q <= owid_d;
            dum_q <= dum_d;
            src_q <= src_d;
            cnt_q <= cnt_d;
        end
    end

    // Input shift register on rising link clock
    always_ff @(posedge clock_i) begin
        if (!rstn_i || cs_fall) begin
            in_q <= '0;
        end else if (rise) begin
            in_q <= in_next;
        end
    end

    // Outgoing byte selection and line drive
    wire data_fall = fall && state_q == SFQ_DATA;
    wire load = data_fall && ocnt_q == 3'h0;
    wire [7:0] stat_byte = (src_q == SFQ_SRC_HI) ? sr_view[15:8]
                                                 : sr_view[7:0];
    wire [7:0] arr_byte = ff_valid ? ff_data : `SFQ_UNDERRUN;
    wire [7:0] new_byte = (src_q == SFQ_SRC_ARRAY) ? arr_byte : stat_byte;
    wire [7:0] cur_byte = load ? new_byte : sh_q;
    wire [2:0] step = sfq_step(owid_q);
    wire pop = load && src_q == SFQ_SRC_ARRAY;
    assign drive_d = (cs_rise || !cs_act || cs_fall) ? '0
                   : data_fall ? sfq_map(cur_byte, owid_q)
                   : drive_q;

    // Output shifter on falling link clock
    always_ff @(posedge clock_i) begin
        if (!rstn_i || cs_fall) begin
            sh_q <= '0;
            ocnt_q <= '0;
        end else if (data_fall) begin
            sh_q <= 8'(cur_byte << step);
            ocnt_q <= 3'(ocnt_q + step);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    // Status write acceptance at frame end
    wire sw_end = cs_rise && state_q == SFQ_STAT_IN;
    wire two = cnt_q == `SFQ_CNT_BYTE2;
    wire sw_ok = sw_end && (two || cnt_q == `SFQ_CNT_BYTE1);
    wire [15:0] sw_val = two ? {in_q[7:0], in_q[15:8]} : {8'h00, in_q[7:0]};
    wire [15:0] sw_mask = two ? `SFQ_SR_MASK
                              : (`SFQ_SR_MASK & `SFQ_SR_LOW);
    wire [15:0] sw_new = (sr_q & ~sw_mask) | (sw_val & sw_mask);
    wire [15:0] sr_next = two ? sw_new : (sw_new & `SFQ_SR_CLR_ONE);

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sr_q <= `SFQ_SR_RESET;
        end else if (sw_ok) begin
            sr_q <= sr_next;
        end
    end

    // Self-timed status write cycle
    wire tw_done = wip_q && tcnt_q == TW_CYCLES - 1;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wip_q <= 1'b0;
            tcnt_q <= '0;
        end else if (sw_ok && !vuse_q) begin
            wip_q <= 1'b1;
            tcnt_q <= '0;
        end else if (tw_done) begin
            wip_q <= 1'b0;
        end else if (wip_q) begin
            tcnt_q <= tcnt_q + 32'h1;
        end
    end

    // Write enable latch, set wins over clear
    wire wel_set = opc_done && opc == `SFQ_OP_SET_WL;
    wire wel_clr = (opc_done && opc == `SFQ_OP_CLR_WL)
                   || tw_done || op_done_i;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wel_q <= 1'b0;
        end else begin
            wel_q <= wel_set || (wel_q && !wel_clr);
        end
    end

    // Volatile enable, cancelled by any other command
    wire vwe_cancel = opc_done || (cs_fall && cont_q);
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            vwe_q <= 1'b0;
            vuse_q <= 1'b0;
        end else begin
            if (vwe_cancel) begin
                vwe_q <= opc_done && opc == `SFQ_OP_VOL_WE;
            end
            if (opc_done && opc == `SFQ_OP_STAT_WR) begin
                vuse_q <= vwe_q;
            end
        end
    end

    // Continuous read mode bits
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            cont_q <= 1'b0;
        end else if (addr_done && dual_q) begin
            cont_q <= in_next[7:4] == `SFQ_CONT_KEY;
        end else if (opc_done && opc == `SFQ_OP_MODE_RST) begin
            cont_q <= 1'b0;
        end
    end

    // Array fetch address, one increment per byte taken
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            addr_q <= '0;
            fetch_q <= 1'b0;
        end else if (cs_rise || !cs_act) begin
            fetch_q <= 1'b0;
        end else if (addr_done) begin
            addr_q <= dual_q ? in_next[31:8] : in_next[23:0];
            fetch_q <= 1'b1;
        end else if (mem_ready_o && mem_valid_i) begin
            addr_q <= addr_q + 24'h1;
        end
    end

    sfq_fifo #(
        .WIDTH(`SFQ_BYTE_W),
        .DEPTH(`SFQ_FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .flush_i(cs_rise || cs_fall),
        .in_valid_i(mem_valid_i && fetch_q),
        .in_data_i(mem_data_i),
        .in_ready_o(ff_in_ready),
        .out_valid_o(ff_valid),
        .out_data_o(ff_data),
        .out_ready_i(pop)
    );

    // Port drive
    assign line_o = drive_q.val;
    assign line_oe_o = drive_q.oe;
    assign mem_addr_o = addr_q;
    assign mem_fetch_o = fetch_q;
    assign mem_ready_o = ff_in_ready && fetch_q && cs_act;
    assign status_o = sr_view;
    assign write_enable_latch_o = wel_q;
    assign write_in_progress_o = busy_all;
    assign cont_mode_o = cont_q;
endmodule

/* File: verification/sfq_host.sv */
// Host controller model driving select, serial clock and data lines
`timescale 1ns/1ps
module sfq_host (
    // Clock
    input wire logic clock_i,
    // Device drive of the data lines
    input wire logic [3:0] line_o,
    input wire logic [3:0] line_oe_o,
    // Host pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] val_o
);
    localparam int HALF = 8;
    // Idle pins at time zero
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        val_o = 4'h0;
    end
    // Step just past a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Select low opens a frame
    task automatic open_frame();
        tick(1);
        cs_n_o = 1'b0;
        tick(HALF);
    endtask
    // Clock parked low, host line values inverted, then select high after last bit
    task automatic close_frame();
        sclk_o = 1'b0;
        val_o = ~val_o;
        tick(HALF);
        cs_n_o = 1'b1;
        tick(2 * HALF);
    endtask
    // n clocks of w lines each, MSB first, odd bits on the upper line
    task automatic shift(input int w, input int n, input logic [63:0] dout,
                         output logic [63:0] din);
        logic [3:0] s;
        din = 64'h0;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            val_o = 4'((dout >> ((n - 1 - i) * w)) & ((64'h1 << w) - 64'h1));
            tick(HALF);
            sclk_o = 1'b1;
            tick(HALF);
            for (int k = 0; k < 4; k++) begin
                s[k] = line_oe_o[k] ? line_o[k] : 1'bx;
            end
            din = (din << w) | ((w == 1) ? 64'(s[1]) :
                  (w == 2) ? 64'(s[1:0]) : 64'(s));
        end
    endtask
endmodule

/* File: verification/sfq_flash_properties.sv */
// Concurrent checks on the ports of the flash command block
`timescale 1ns/1ps
module sfq_flash_props #(
    parameter int unsigned TW_CYCLES = 500
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Link and array inputs
    input wire logic cs_n_i,
    input wire logic busy_i,
    input wire logic op_done_i,
    input wire logic mem_valid_i,
    // Observed outputs
    input wire logic [3:0] line_oe_o,
    input wire logic [23:0] mem_addr_o,
    input wire logic mem_fetch_o,
    input wire logic mem_ready_o,
    input wire logic [15:0] status_o,
    input wire logic write_enable_latch_o,
    input wire logic write_in_progress_o,
    input wire logic cont_mode_o
);
    logic [15:0] len_q, len_d;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // Frame end and end of a self-timed cycle
    sequence s_frame_end;
        $rose(cs_n_i);
    endsequence
    sequence s_cycle_end;
        $fell(write_in_progress_o) && !$past(busy_i);
    endsequence
    // Length of the running self-timed cycle
    assign len_d = (write_in_progress_o && !busy_i) ? len_q + 16'h1 : 16'h0;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            len_q <= 16'h0;
        end else begin
            len_q <= len_d;
        end
    end
    AST_CYCLE_LEN: assert property (s_cycle_end |->
        len_q >= 16'(TW_CYCLES - 1) && len_q <= 16'(TW_CYCLES + 1))
        else $error("self-timed cycle length off");
    AST_WEL_CYCLE_END: assert property (s_cycle_end |->
        ##[0:1] !write_enable_latch_o) else $error("latch kept after cycle");
    AST_OP_DONE_CLR: assert property (op_done_i |=>
        !write_enable_latch_o) else $error("latch kept after op done");
    AST_BUSY_WIP: assert property (busy_i |->
        write_in_progress_o && status_o[0]) else $error("busy not shown");
    AST_SR_FIXED: assert property (
        {status_o[15], status_o[13:11]} == 4'h0) else $error("fixed bit set");
    AST_OE_DROP: assert property (s_frame_end |->
        ##[1:5] line_oe_o == 4'h0) else $error("lines driven after frame");
    AST_OE_WIDTH: assert property (
        line_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad line set");
    AST_MEM_READY: assert property (mem_ready_o |->
        mem_fetch_o && !$past(cs_n_i, 2)) else $error("ready outside frame");
    AST_ADDR_INC: assert property (mem_valid_i && mem_ready_o |=>
        mem_addr_o == $past(mem_addr_o) + 24'h1) else $error("no increment");
    AST_READ_REFUSED: assert property ($rose(mem_fetch_o) |->
        !$past(write_in_progress_o)) else $error("read while busy");
    AST_CONT_STABLE: assert property (cs_n_i [*4] |->
        $stable(cont_mode_o)) else $error("mode changed outside frame");
endmodule

bind sfq_flash sfq_flash_props #(.TW_CYCLES(TW_CYCLES)) u_props (
    .clock_i, .rstn_i, .cs_n_i, .busy_i, .op_done_i, .mem_valid_i,
    .line_oe_o, .mem_addr_o, .mem_fetch_o, .mem_ready_o, .status_o,
    .write_enable_latch_o, .write_in_progress_o, .cont_mode_o);

/* File: verification/sfq_flash_test.sv */
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module sfq_flash_test;
    import sfq_pkg::*;
    localparam int unsigned TW = 600;
    logic clock_i, rstn_i, wp_n_i, busy_i, op_done_i, cs_n, sclk;
    logic mem_fetch_o, mem_ready_o, write_enable_latch, write_in_progress, cont;
    logic [3:0] hval, line_o, line_oe_o;
    logic [23:0] mem_addr_o;
    logic [15:0] status_o;
    logic [63:0] d;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Wire level: device drive wins, else the host value
    wire logic [3:0] line_i = (line_oe_o & line_o) | (~line_oe_o & hval);
    // Array contents are a fixed function of the address
    wire logic [7:0] mem_data_i = mem_addr_o[7:0] ^ 8'hA5;
    sfq_flash #(.TW_CYCLES(TW)) dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .wp_n_i(wp_n_i), .line_i(line_i),
        .line_o(line_o), .line_oe_o(line_oe_o), .busy_i(busy_i),
        .op_done_i(op_done_i), .mem_addr_o(mem_addr_o),
        .mem_fetch_o(mem_fetch_o), .mem_valid_i(mem_fetch_o),
        .mem_data_i(mem_data_i), .mem_ready_o(mem_ready_o),
        .status_o(status_o), .write_enable_latch_o(write_enable_latch),
        .write_in_progress_o(write_in_progress), .cont_mode_o(cont));
    sfq_host host (.clock_i(clock_i), .line_o(line_o),
        .line_oe_o(line_oe_o), .cs_n_o(cs_n), .sclk_o(sclk), .val_o(hval));
    // 100 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // Hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            complete_run();
        end
    end
    // Verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Opcode-only frame
    task automatic op_only(input logic [7:0] op);
        host.open_frame();
        host.shift(1, 8, 64'(op), d);
        host.close_frame();
    endtask
    // Status write frame, low byte first, n data bits
    task automatic wr_status(input logic [15:0] v, input int n);
        host.open_frame();
        host.shift(1, 8, 64'h01, d);
        host.shift(1, n, 64'({v[7:0], v[15:8]}) >> (16 - n), d);
        host.close_frame();
    endtask
    // Status read frame collecting n bits
    task automatic rd_status(input logic [7:0] op, input int n);
        host.open_frame();
        host.shift(1, 8, 64'(op), d);
        host.shift(1, n, 64'h0, d);
        host.close_frame();
    endtask
    // Array read with single-line address
    task automatic rd(input logic [7:0] op, input int w, input logic [23:0] a,
                      input logic dum, input int nb);
        host.open_frame();
        host.shift(1, 8, 64'(op), d);
        host.shift(1, 24, 64'(a), d);
        if (dum) host.shift(1, 8, 64'h0, d);
        host.shift(w, nb * 8 / w, 64'h0, d);
        host.close_frame();
    endtask
    // Dual address read, opcode left out in continuous mode
    task automatic dio(input logic op, input logic [23:0] a,
                       input logic [7:0] m, input int nb);
        host.open_frame();
        if (op) host.shift(1, 8, 64'hBB, d);
        host.shift(2, 16, 64'({a, m}), d);
        host.shift(2, nb * 4, 64'h0, d);
        host.close_frame();
    endtask
    // Poll the progress flag until the cycle ends
    task automatic wait_idle();
        for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) begin
            host.tick(1);
        end
        check(64'(write_in_progress), 64'h0);
    endtask
    // Latch set, clear and operation-end clear
    task automatic t_latch();
        op_only(8'h06);
        check(64'(write_enable_latch), 64'h1);
        op_only(8'h04);
        check(64'(write_enable_latch), 64'h0);
        op_only(8'h06);
        op_done_i = 1'b1;
        host.tick(1);
        op_done_i = 1'b0;
        host.tick(1);
        check(64'(write_enable_latch), 64'h0);
    endtask
    // Nonvolatile status writes and reads during the cycle
    task automatic t_status();
        wr_status(16'h5A3C, 16);
        check(64'(status_o), 64'h0);
        op_only(8'h06);
        wr_status(16'h5A3C, 16);
        check(64'(status_o), 64'h423F);
        rd_status(8'h05, 16);
        check(d, 64'h3F3F);
        wait_idle();
        check(64'(status_o), 64'h423C);
        rd_status(8'h35, 8);
        check(d, 64'h42);
        op_only(8'h06);
        wr_status(16'h00FC, 8);
        wait_idle();
        check(64'(status_o), 64'h00FC);
    endtask
    // Hardware protect, short frame and volatile enable
    task automatic t_protect();
        wp_n_i = 1'b0;
        op_only(8'h06);
        wr_status(16'h0000, 16);
        check(64'(status_o), 64'h00FE);
        wp_n_i = 1'b1;
        wr_status(16'h0000, 12);
        check(64'(status_o), 64'h00FE);
        op_only(8'h04);
        op_only(8'h50);
        check(64'(write_enable_latch), 64'h0);
        wr_status(16'h0000, 16);
        check(64'(status_o), 64'h0);
        op_only(8'h50);
        op_only(8'h04);
        wr_status(16'h00FC, 16);
        check(64'(status_o), 64'h0);
    endtask
    // Array reads of every width and continuous mode
    task automatic t_reads();
        rd(8'h03, 1, 24'h00FFFE, 1'b0, 3);
        check(d, 64'h5B5AA5);
        rd(8'h0B, 1, 24'h000010, 1'b1, 2);
        check(d, 64'hB5B4);
        rd(8'h3B, 2, 24'h000020, 1'b1, 2);
        check(d, 64'h8584);
        rd(8'h6B, 4, 24'h000030, 1'b1, 2);
        check(d, 64'h9594);
        busy_i = 1'b1;
        rd(8'h03, 1, 24'h000000, 1'b0, 1);
        check(d, {56'h0, 8'hXX});
        busy_i = 1'b0;
        dio(1'b1, 24'h000040, 8'hA5, 2);
        check(d, 64'hE5E4);
        check(64'(cont), 64'h1);
        dio(1'b0, 24'h000050, 8'hA3, 1);
        check(d, 64'hF5);
        dio(1'b0, 24'h000060, 8'h00, 1);
        check(d, 64'hC5);
        check(64'(cont), 64'h0);
    endtask
    // Reset, then the scenarios in turn
    initial begin
        rstn_i = 1'b0;
        wp_n_i = 1'b1;
        busy_i = 1'b0;
        op_done_i = 1'b0;
        repeat (6) @(posedge clock_i);
        #1;
        rstn_i = 1'b1;
        host.tick(2);
        t_latch();
        t_status();
        t_protect();
        t_reads();
        complete_run();
    end
endmodule
